// >>> pkg/rfa_consts.svh
// Constants for the register field access bank
`ifndef RFA_CONSTS_SVH
`define RFA_CONSTS_SVH
`define RFA_OFS_RW    4'h0
`define RFA_OFS_RO    4'h1
`define RFA_OFS_RC    4'h2
`define RFA_OFS_RW1C  4'h3
`define RFA_OFS_RW1S  4'h4
`define RFA_OFS_W1C   4'h5
`define RFA_OFS_WO    4'h6
`define RFA_RST_RW    8'h00
`define RFA_RST_RO    8'h00
`define RFA_RST_RC    8'h00
`define RFA_RST_RW1C  8'h00
`define RFA_RST_RW1S  8'h00
`define RFA_RST_W1C   8'h00
`define RFA_RST_WO    8'h00
`define RFA_RSVD_MSB  7
`define RFA_RSVD_LSB  6
`endif

// >>> pkg/rfa_pkg.sv
// Types for the register field access bank
package rfa_pkg;
	typedef logic [7:0] rfa_word_t;
	typedef enum logic [1:0] {
		RFA_IDLE  = 2'b00,
		RFA_RDACK = 2'b01
	} rfa_state_e;
endpackage

// >>> src/rfa_bank.sv
// Register bank showing each field access type
`timescale 1ns/1ps
`include "rfa_consts.svh"
module rfa_bank #(
	parameter logic [15:0] BASE_ADDR = 16'h0000
) (
	input  wire logic               sys_clk,
	input  wire logic               rst,
	input  wire logic               clk_en,
	input  wire logic               sel,
	input  wire logic               wr,
	input  wire logic [15:0]        addr,
	input  wire rfa_pkg::rfa_word_t wdata,
	input  wire rfa_pkg::rfa_word_t hw_status_set,
	input  wire rfa_pkg::rfa_word_t hw_count_in,
	input  wire rfa_pkg::rfa_word_t hw_ro_value,
	input  wire rfa_pkg::rfa_word_t hw_set_clear,
	output rfa_pkg::rfa_word_t      rdata,
	output logic                    rd_valid,
	output rfa_pkg::rfa_word_t      ctrl_out,
	output rfa_pkg::rfa_word_t      flags_out,
	output rfa_pkg::rfa_word_t      wo_out
);
	rfa_pkg::rfa_word_t rw_q, ro_q, rc_q, st_q, set_q, w1c_q, wo_q, rdata_q;
	rfa_pkg::rfa_word_t rw_d, rc_d, st_d, set_d, w1c_d, wo_d, rdata_d;
	logic               rd_valid_q;
	rfa_pkg::rfa_state_e state_q;
	function automatic logic hit(input logic [15:0] a, input logic [3:0] ofs);
		hit = (a[15:4] == BASE_ADDR[15:4]) && (a[3:0] == ofs);
	endfunction
	wire do_wr = clk_en && sel && wr;
	wire do_rd = clk_en && sel && !wr;
	wire wr_rw   = do_wr && hit(addr, `RFA_OFS_RW);
	wire rd_rc   = do_rd && hit(addr, `RFA_OFS_RC);
	wire wr_st   = do_wr && hit(addr, `RFA_OFS_RW1C);
	wire wr_set  = do_wr && hit(addr, `RFA_OFS_RW1S);
	wire wr_w1c  = do_wr && hit(addr, `RFA_OFS_W1C);
	wire wr_wo   = do_wr && hit(addr, `RFA_OFS_WO);
	wire rfa_pkg::rfa_word_t rsvd_keep = 8'h3F;
	assign rw_d  = wr_rw ? (wdata & rsvd_keep) : rw_q;
	// clear on read, new count wins
	assign rc_d  = (rd_rc ? 8'h00 : rc_q) | hw_count_in;
	assign st_d  = (wr_st ? (st_q & ~wdata) : st_q) | hw_status_set;
	assign set_d = (wr_set ? (set_q | wdata) : set_q) & ~(wr_set ? 8'h00 : hw_set_clear);
	assign w1c_d = (wr_w1c ? (w1c_q & ~wdata) : w1c_q) | hw_status_set;
	assign wo_d  = wr_wo ? wdata : wo_q;
	wire [3:0] ofs = addr[3:0];
	wire       in_blk = (addr[15:4] == BASE_ADDR[15:4]);
	always_comb begin
		rdata_d = 8'h00;
		if (in_blk) begin
			case (ofs)
				`RFA_OFS_RW:   rdata_d = rw_q;
				`RFA_OFS_RO:   rdata_d = ro_q;
				`RFA_OFS_RC:   rdata_d = rc_q;
				`RFA_OFS_RW1C: rdata_d = st_q;
				`RFA_OFS_RW1S: rdata_d = set_q;
				default:       rdata_d = 8'h00;
			endcase
		end
	end
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rw_q       <= `RFA_RST_RW;
			ro_q       <= `RFA_RST_RO;
			rc_q       <= `RFA_RST_RC;
			st_q       <= `RFA_RST_RW1C;
			set_q      <= `RFA_RST_RW1S;
			w1c_q      <= `RFA_RST_W1C;
			wo_q       <= `RFA_RST_WO;
			rdata_q    <= 8'h00;
			rd_valid_q <= 1'b0;
			state_q    <= rfa_pkg::RFA_IDLE;
		end else if (clk_en) begin
			rw_q       <= rw_d;
			ro_q       <= hw_ro_value;
			rc_q       <= rc_d;
			st_q       <= st_d;
			set_q      <= set_d;
			w1c_q      <= w1c_d;
			wo_q       <= wo_d;
			rdata_q    <= do_rd ? rdata_d : 8'h00;
			rd_valid_q <= do_rd;
			case (state_q)
				rfa_pkg::RFA_IDLE:  state_q <= do_rd ? rfa_pkg::RFA_RDACK : rfa_pkg::RFA_IDLE;
				rfa_pkg::RFA_RDACK: state_q <= do_rd ? rfa_pkg::RFA_RDACK : rfa_pkg::RFA_IDLE;
				default:            state_q <= rfa_pkg::RFA_IDLE;
			endcase
		end
	end
	assign rdata     = rdata_q;
	assign rd_valid  = rd_valid_q;
	assign ctrl_out  = rw_q;
	assign flags_out = set_q;
	assign wo_out    = wo_q;

	property p_rc_clear;
		@(posedge sys_clk) disable iff (rst)
		(rd_rc && hw_count_in == 8'h00) |=> (rc_q == 8'h00);
	endproperty
	a_rc_clear: assert property (p_rc_clear) else $error("Read-clear field not cleared");

	property p_rc_new;
		@(posedge sys_clk) disable iff (rst)
		(clk_en && hw_count_in != 8'h00) |=> ((rc_q & $past(hw_count_in)) == $past(hw_count_in));
	endproperty
	a_rc_new: assert property (p_rc_new) else $error("Read-clear count lost");

	property p_rw_store;
		@(posedge sys_clk) disable iff (rst)
		wr_rw |=> (rw_q == ($past(wdata) & rsvd_keep));
	endproperty
	a_rw_store: assert property (p_rw_store) else $error("Read/write field lost data");

	property p_w1c_zero;
		@(posedge sys_clk) disable iff (rst)
		(wr_st && wdata == 8'h00) |=> (st_q == ($past(st_q) | $past(hw_status_set)));
	endproperty
	a_w1c_zero: assert property (p_w1c_zero) else $error("Zero write changed status");

	property p_wo1c_zero;
		@(posedge sys_clk) disable iff (rst)
		(wr_w1c && wdata == 8'h00) |=> (w1c_q == ($past(w1c_q) | $past(hw_status_set)));
	endproperty
	a_wo1c_zero: assert property (p_wo1c_zero) else $error("Zero write changed clear bit");

	property p_w1c_one;
		@(posedge sys_clk) disable iff (rst)
		wr_st |=> ((st_q & $past(wdata) & ~$past(hw_status_set)) == 8'h00);
	endproperty
	a_w1c_one: assert property (p_w1c_one) else $error("One write did not clear");

	property p_wo1c_one;
		@(posedge sys_clk) disable iff (rst)
		wr_w1c |=> ((w1c_q & $past(wdata) & ~$past(hw_status_set)) == 8'h00);
	endproperty
	a_wo1c_one: assert property (p_wo1c_one) else $error("One write did not clear bit");

	property p_w1c_new;
		@(posedge sys_clk) disable iff (rst)
		(clk_en && (hw_status_set != 8'h00)) |=> ((st_q & $past(hw_status_set)) == $past(hw_status_set));
	endproperty
	a_w1c_new: assert property (p_w1c_new) else $error("New status lost");

	property p_w1s_zero;
		@(posedge sys_clk) disable iff (rst)
		(wr_set && wdata == 8'h00) |=> (set_q == $past(set_q));
	endproperty
	a_w1s_zero: assert property (p_w1s_zero) else $error("Zero write changed set bit");

	property p_w1s_one;
		@(posedge sys_clk) disable iff (rst)
		wr_set |=> ((set_q & $past(wdata)) == $past(wdata));
	endproperty
	a_w1s_one: assert property (p_w1s_one) else $error("One write did not set");

	property p_w1s_hwclr;
		@(posedge sys_clk) disable iff (rst)
		(clk_en && !wr_set && hw_set_clear != 8'h00) |=> ((set_q & $past(hw_set_clear)) == 8'h00);
	endproperty
	a_w1s_hwclr: assert property (p_w1s_hwclr) else $error("Hardware clear ignored");

	// reserved bits zero, judged on the offset that was read
	property p_rsvd;
		@(posedge sys_clk) disable iff (rst)
		rd_valid |-> (rdata[`RFA_RSVD_MSB:`RFA_RSVD_LSB] == 2'b00 || $past(ofs) != `RFA_OFS_RW);
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("Reserved bits not zero");

	property p_w1c_rd;
		@(posedge sys_clk) disable iff (rst)
		(rd_valid && $past(ofs) == `RFA_OFS_W1C) |-> (rdata == 8'h00);
	endproperty
	a_w1c_rd: assert property (p_w1c_rd) else $error("Write-only clear register read data");

	property p_wo;
		@(posedge sys_clk) disable iff (rst)
		wr_wo |=> (wo_out == $past(wdata));
	endproperty
	a_wo: assert property (p_wo) else $error("Write-only write lost");

	// frozen while disabled, so a stalled bus cannot corrupt state
	property p_freeze;
		@(posedge sys_clk) disable iff (rst)
		!clk_en |=> (rw_q == $past(rw_q) && st_q == $past(st_q) && set_q == $past(set_q));
	endproperty
	a_freeze: assert property (p_freeze) else $error("State moved while disabled");

	c_rc:  cover property (@(posedge sys_clk) rd_rc && rc_q != 8'h00);
	c_st:  cover property (@(posedge sys_clk) wr_st && hw_status_set != 8'h00);
	c_set: cover property (@(posedge sys_clk) wr_set && wdata != 8'h00);
	c_w1c: cover property (@(posedge sys_clk) wr_w1c && wdata != 8'h00);
	c_frz: cover property (@(posedge sys_clk) !clk_en && sel);
endmodule // rfa_bank

// >>> tb/test_rfa_bank.sv
// Self-checking bench for the field access bank
`timescale 1ns/1ps
`include "rfa_consts.svh"
module test_rfa_bank;
	localparam logic [15:0] BASE = 16'h4000;
	logic               sys_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, sel = 1'b0, wr = 1'b0;
	logic [15:0]        addr = 16'h0000, bs = BASE;
	rfa_pkg::rfa_word_t wdata = 8'h00, hs = 8'h00, hc = 8'h00, ro = 8'h00, sc = 8'h00;
	rfa_pkg::rfa_word_t rdata, ctrl_out, flags_out, wo_out, a, b;
	logic               rd_valid;
	rfa_pkg::rfa_word_t expq[$];
	int                 mismatches = 0;
	int                 compares = 0;

	rfa_bank #(.BASE_ADDR(BASE)) dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
		.sel(sel), .wr(wr), .addr(addr), .wdata(wdata), .hw_status_set(hs),
		.hw_count_in(hc), .hw_ro_value(ro), .hw_set_clear(sc), .rdata(rdata),
		.rd_valid(rd_valid), .ctrl_out(ctrl_out), .flags_out(flags_out), .wo_out(wo_out));

	always #25 sys_clk = ~sys_clk;

	task automatic chk(input string n, input rfa_pkg::rfa_word_t e, input rfa_pkg::rfa_word_t g);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic stop_test();
		if (mismatches == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Sel is left high so accesses run back to back
	task automatic acc(input logic w, input logic [3:0] o, input rfa_pkg::rfa_word_t d,
			input rfa_pkg::rfa_word_t e);
		sel = 1'b1;
		wr = w;
		addr = {bs[15:4], o};
		wdata = d;
		if (!w)
			expq.push_back(e);
		@(negedge sys_clk);
	endtask

	// One-cycle hardware event; never call twice in a row
	task automatic ev(input rfa_pkg::rfa_word_t s, input rfa_pkg::rfa_word_t c);
		sel = 1'b0;
		hs = s;
		hc = c;
		@(negedge sys_clk);
		hs = 8'h00;
		hc = 8'h00;
	endtask

	always @(negedge sys_clk) begin
		if (rd_valid === 1'b1) begin
			if (expq.size() > 0)
				chk("rdata", expq.pop_front(), rdata);
			else
				chk("rd_valid", 8'h00, 8'h01);
		end
	end

	initial begin
		#(50 * 2000);
		mismatches++;
		stop_test();
	end

	initial begin
		a = 8'($urandom(4)) | 8'h81;
		ro = 8'($urandom());
		repeat (12) @(negedge sys_clk);
		rst = 1'b0;
		chk("ctrl_out", 8'h00, ctrl_out);
		for (int i = 0; i < 5; i++)
			acc(1'b0, 4'(i), 8'h00, (i == 1) ? ro : 8'h00);
		acc(1'b1, `RFA_OFS_RW, a, 8'h00);
		acc(1'b0, `RFA_OFS_RW, 8'h00, a & 8'h3F);
		chk("ctrl_out", a & 8'h3F, ctrl_out);
		acc(1'b1, `RFA_OFS_RW, a & 8'h3F, 8'h00);
		clk_en = 1'b0;
		acc(1'b1, `RFA_OFS_RW, ~a, 8'h00);
		clk_en = 1'b1;
		chk("ctrl_out", a & 8'h3F, ctrl_out);
		acc(1'b1, `RFA_OFS_RO, `RFA_RST_RO, 8'h00);
		acc(1'b0, `RFA_OFS_RO, 8'h00, ro);
		ev(8'h00, a);
		acc(1'b0, `RFA_OFS_RC, 8'h00, a);
		acc(1'b0, `RFA_OFS_RC, 8'h00, 8'h00);
		// write back clears reported bits only
		b = 8'($urandom()) & ~a;
		ev(a, 8'h00);
		acc(1'b0, `RFA_OFS_RW1C, 8'h00, a);
		ev(b, 8'h00);
		acc(1'b1, `RFA_OFS_RW1C, a, 8'h00);
		acc(1'b1, `RFA_OFS_RW1C, 8'h00, 8'h00);
		acc(1'b0, `RFA_OFS_RW1C, 8'h00, b);
		acc(1'b1, `RFA_OFS_RW1S, a, 8'h00);
		acc(1'b1, `RFA_OFS_RW1S, 8'h00, 8'h00);
		acc(1'b0, `RFA_OFS_RW1S, 8'h00, a);
		chk("flags_out", a, flags_out);
		sel = 1'b0;
		sc = a;
		@(negedge sys_clk);
		sc = 8'h00;
		acc(1'b0, `RFA_OFS_RW1S, 8'h00, 8'h00);
		acc(1'b1, `RFA_OFS_WO, a, 8'h00);
		acc(1'b1, `RFA_OFS_W1C, a, 8'h00);
		acc(1'b0, 4'h7, 8'h00, 8'h00);
		bs = 16'h5000;
		acc(1'b0, `RFA_OFS_RW, 8'h00, 8'h00);
		sel = 1'b0;
		chk("wo_out", a, wo_out);
		repeat (3) @(negedge sys_clk);
		chk("pending", 8'h00, 8'(expq.size()));
		stop_test();
	end
endmodule // test_rfa_bank
